// File: verilog/emt_pkg.sv
// Purpose: Constants and types for the external memory bus timing sequencer.
// Assumes: One clock domain, the system clock, at 250 MHz.
// Notes: Timing fields are counts of system-clock periods.
`default_nettype none
package emt_pkg;
  localparam int unsigned EMT_CLK_PERIOD_NS = 4;
  // Mode field encodings (bits of the configuration mode field).
  localparam logic [2:0] EMT_MODE_MUX_NB_A = 3'h1;
  localparam logic [2:0] EMT_MODE_MUX_BANK = 3'h2;
  localparam logic [2:0] EMT_MODE_MUX_NB_B = 3'h3;
  localparam logic [2:0] EMT_MODE_NMX_NB_A = 3'h5;
  localparam logic [2:0] EMT_MODE_NMX_BANK = 3'h6;
  localparam logic [2:0] EMT_MODE_NMX_NB_B = 3'h7;
  // Timing register field positions and reset value.
  localparam int unsigned EMT_TC_SETUP_LSB = 6;
  localparam int unsigned EMT_TC_WIDTH_LSB = 2;
  localparam int unsigned EMT_TC_HOLD_LSB = 0;
  localparam logic [7:0] EMT_TC_RESET = 8'hff;
  // Fixed overhead of every off-chip move in cycles, less one (the tail loads it minus three; a move takes at least five).
  localparam logic [4:0] EMT_BASE_CYCLES = 5'h4;
  typedef enum logic [2:0] {
    EMT_IDLE,
    EMT_ALE_HI,
    EMT_ALE_LO,
    EMT_SETUP,
    EMT_STROBE,
    EMT_HOLD,
    EMT_TAIL
  } emt_state_type;
endpackage
`default_nettype wire

// File: verilog/emt_phase_cnt.sv
// Purpose: Down counter that times one phase of an off-chip bus cycle.
// Assumes: Load and count never in the same cycle are needed; load wins.
// Notes: Done is high while the count is zero.
`default_nettype none
module emt_phase_cnt #(
  parameter int unsigned W = 5
) (
  input wire logic core_clk, // system clock
  input wire logic rst_b, // async reset, active low
  input wire logic load, // load a new count
  input wire logic [W-1:0] value, // count to load
  output logic done // count has reached zero
);
  logic [W-1:0] cnt_r;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= '0;
    end else if (load) begin
      cnt_r <= value;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end
  assign done = (cnt_r == '0);
endmodule
`default_nettype wire

// File: verilog/emt_seq.sv
// Purpose: Sequencer turning CPU external data moves into off-chip bus cycles.
// Assumes: Requests are synchronous to core_clk and held until done pulses.
// Notes: Strobes are active low; ALE is active high.
`default_nettype none
module emt_seq
  import emt_pkg::*;
(
  input wire logic core_clk, // system clock
  input wire logic rst_b, // async reset, active low
  input wire logic [2:0] ext_mem_config, // mode field
  input wire logic [1:0] ale_width_cfg, // ALE high/low time minus one
  input wire logic port_select_upper, // route bus to upper ports
  input wire logic [7:0] ext_mem_page, // page register, upper address for 8-bit moves
  input wire logic tc_wr, // load new timing value
  input wire logic [7:0] tc_wdata, // timing value to load
  input wire logic req, // off-chip move request
  input wire logic req_write, // 1 for write, 0 for read
  input wire logic req_wide, // 1 for 16-bit pointer move, 0 for 8-bit pointer move
  input wire logic [15:0] wide_data_pointer, // 16-bit address
  input wire logic [7:0] indirect_pointer, // 8-bit pointer value
  input wire logic [7:0] wr_data, // data to write
  output logic [7:0] ext_mem_timing, // current timing register
  output logic busy, // move in progress
  output logic done, // one-cycle pulse at end of move
  output logic [7:0] rd_data, // data captured on a read
  output logic [7:0] lo_addr_hi, // lower ports: upper address byte
  output logic lo_addr_hi_oe, // lower ports: upper address driven
  output logic [7:0] lo_addr_lo, // lower ports: low address (non-mux)
  output logic lo_addr_lo_oe, // lower ports: low address driven
  output logic [7:0] lo_ad_out, // lower ports: data/mux address out
  output logic lo_ad_oe, // lower ports: data bus driven
  input wire logic [7:0] lo_ad_in, // lower ports: data bus in
  output logic lo_ale, // lower ports: address latch enable
  output logic lo_rd_b, // lower ports: read strobe, active low
  output logic lo_wr_b, // lower ports: write strobe, active low
  output logic [7:0] up_addr_hi, // upper ports: upper address byte
  output logic up_addr_hi_oe, // upper ports: upper address driven
  output logic [7:0] up_addr_lo, // upper ports: low address (non-mux)
  output logic up_addr_lo_oe, // upper ports: low address driven
  output logic [7:0] up_ad_out, // upper ports: data/mux address out
  output logic up_ad_oe, // upper ports: data bus driven
  input wire logic [7:0] up_ad_in, // upper ports: data bus in
  output logic up_ale, // upper ports: address latch enable
  output logic up_rd_b, // upper ports: read strobe, active low
  output logic up_wr_b // upper ports: write strobe, active low
);
  emt_state_type st_r, st_nxt;
  logic [7:0] tc_r;
  logic [15:0] addr_r;
  logic [7:0] wdat_r;
  logic wr_r, mux_r, hi_en_r, upper_r;
  logic [1:0] ale_r;
  logic cnt_load;
  logic [4:0] cnt_val;
  logic cnt_done;

  function automatic logic is_mux(input logic [2:0] m);
    return (m == EMT_MODE_MUX_NB_A) || (m == EMT_MODE_MUX_BANK) ||
           (m == EMT_MODE_MUX_NB_B);
  endfunction

  wire logic [1:0] f_setup = tc_r[EMT_TC_SETUP_LSB +: 2];
  wire logic [3:0] f_width = tc_r[EMT_TC_WIDTH_LSB +: 4];
  wire logic [1:0] f_hold = tc_r[EMT_TC_HOLD_LSB +: 2];
  wire logic req_mux = is_mux(ext_mem_config);
  // Bank select applies only to 8-bit pointer moves in modes 010 and 110.
  wire logic bank_sel = (ext_mem_config == EMT_MODE_MUX_BANK) ||
                        (ext_mem_config == EMT_MODE_NMX_BANK);
  wire logic [15:0] req_addr = req_wide ? wide_data_pointer :
                               {ext_mem_page, indirect_pointer};
  wire logic req_hi_en = req_wide || bank_sel;
  wire logic start = (st_r == EMT_IDLE) && req;

  // Phase lengths are loaded as length minus one, so one cycle loads zero.
  always_comb begin
    st_nxt = st_r;
    cnt_load = 1'b0;
    cnt_val = 5'h0;
    case (st_r)
      EMT_IDLE: begin
        if (req) begin
          cnt_load = 1'b1;
          if (req_mux) begin
            st_nxt = EMT_ALE_HI;
            cnt_val = {3'h0, ale_width_cfg};
          end else begin
            st_nxt = EMT_SETUP;
            cnt_val = {3'h0, f_setup};
          end
        end
      end
      EMT_ALE_HI: begin
        if (cnt_done) begin
          st_nxt = EMT_ALE_LO;
          cnt_load = 1'b1;
          cnt_val = {3'h0, ale_r};
        end
      end
      EMT_ALE_LO: begin
        if (cnt_done) begin
          st_nxt = EMT_SETUP;
          cnt_load = 1'b1;
          cnt_val = {3'h0, f_setup};
        end
      end
      EMT_SETUP: begin
        // The setup phase always lasts at least one cycle; a zero setup
        // field still gives that one, since the count holds length minus one.
        if (cnt_done) begin
          st_nxt = EMT_STROBE;
          cnt_load = 1'b1;
          cnt_val = {1'b0, f_width};
        end
      end
      EMT_STROBE: begin
        if (cnt_done) begin
          st_nxt = EMT_HOLD;
          cnt_load = 1'b1;
          cnt_val = {3'h0, f_hold};
        end
      end
      EMT_HOLD: begin
        if (cnt_done) begin
          st_nxt = EMT_TAIL;
          cnt_load = 1'b1;
          cnt_val = EMT_BASE_CYCLES - 5'h3;
        end
      end
      EMT_TAIL: begin
        if (cnt_done) begin
          st_nxt = EMT_IDLE;
        end
      end
      default: st_nxt = EMT_IDLE;
    endcase
  end

  emt_phase_cnt #(.W(5)) u_cnt (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .load(cnt_load),
    .value(cnt_val),
    .done(cnt_done)
  );

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tc_r <= EMT_TC_RESET;
    end else if (tc_wr && st_r == EMT_IDLE) begin
      tc_r <= tc_wdata;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= EMT_IDLE;
      addr_r <= 16'h0;
      wdat_r <= 8'h0;
      wr_r <= 1'b0;
      mux_r <= 1'b0;
      hi_en_r <= 1'b0;
      upper_r <= 1'b0;
      ale_r <= 2'h0;
    end else begin
      st_r <= st_nxt;
      if (start) begin
        addr_r <= req_addr;
        wdat_r <= wr_data;
        wr_r <= req_write;
        mux_r <= req_mux;
        hi_en_r <= req_hi_en;
        upper_r <= port_select_upper;
        ale_r <= ale_width_cfg;
      end
    end
  end

  // Next values of the pin outputs; in idle every enable is off and no strobe or ALE is active.
  wire logic active_nxt = (st_nxt != EMT_IDLE);
  wire logic in_addr_ph = (st_nxt == EMT_ALE_HI) || (st_nxt == EMT_ALE_LO);
  wire logic strobe_nxt = (st_nxt == EMT_STROBE);
  wire logic wmux = start ? req_mux : mux_r;
  wire logic wwr = start ? req_write : wr_r;
  wire logic whi = start ? req_hi_en : hi_en_r;
  wire logic wup = start ? port_select_upper : upper_r;
  wire logic [15:0] wadr = start ? req_addr : addr_r;
  wire logic [7:0] wdat = start ? wr_data : wdat_r;
  wire logic wdrive = wwr && ((st_nxt == EMT_SETUP) || strobe_nxt ||
                              (st_nxt == EMT_HOLD));
  wire logic ad_oe_nxt = active_nxt && ((wmux && in_addr_ph) || wdrive);
  wire logic [7:0] ad_nxt = (wmux && in_addr_ph) ? wadr[7:0] : wdat;
  wire logic ale_nxt = wmux && (st_nxt == EMT_ALE_HI);
  wire logic rd_b_nxt = !(strobe_nxt && !wwr);
  wire logic wr_b_nxt = !(strobe_nxt && wwr);
  wire logic hi_oe_nxt = active_nxt && whi;
  wire logic lo_oe_nxt = active_nxt && !wmux;
  // Read data sampled on the last strobe cycle, when the strobe rises.
  wire logic rd_cap = (st_r == EMT_STROBE) && cnt_done && !wr_r;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      lo_addr_hi <= 8'h0;
      lo_addr_hi_oe <= 1'b0;
      lo_addr_lo <= 8'h0;
      lo_addr_lo_oe <= 1'b0;
      lo_ad_out <= 8'h0;
      lo_ad_oe <= 1'b0;
      lo_ale <= 1'b0;
      lo_rd_b <= 1'b1;
      lo_wr_b <= 1'b1;
      up_addr_hi <= 8'h0;
      up_addr_hi_oe <= 1'b0;
      up_addr_lo <= 8'h0;
      up_addr_lo_oe <= 1'b0;
      up_ad_out <= 8'h0;
      up_ad_oe <= 1'b0;
      up_ale <= 1'b0;
      up_rd_b <= 1'b1;
      up_wr_b <= 1'b1;
      busy <= 1'b0;
      done <= 1'b0;
      rd_data <= 8'h0;
      ext_mem_timing <= EMT_TC_RESET;
    end else begin
      lo_addr_hi <= wadr[15:8];
      lo_addr_hi_oe <= hi_oe_nxt && !wup;
      lo_addr_lo <= wadr[7:0];
      lo_addr_lo_oe <= lo_oe_nxt && !wup;
      lo_ad_out <= ad_nxt;
      lo_ad_oe <= ad_oe_nxt && !wup;
      lo_ale <= ale_nxt && !wup;
      lo_rd_b <= rd_b_nxt || wup;
      lo_wr_b <= wr_b_nxt || wup;
      up_addr_hi <= wadr[15:8];
      up_addr_hi_oe <= hi_oe_nxt && wup;
      up_addr_lo <= wadr[7:0];
      up_addr_lo_oe <= lo_oe_nxt && wup;
      up_ad_out <= ad_nxt;
      up_ad_oe <= ad_oe_nxt && wup;
      up_ale <= ale_nxt && wup;
      up_rd_b <= rd_b_nxt || !wup;
      up_wr_b <= wr_b_nxt || !wup;
      busy <= active_nxt;
      done <= (st_r == EMT_TAIL) && cnt_done;
      if (rd_cap) begin
        rd_data <= upper_r ? up_ad_in : lo_ad_in;
      end
      ext_mem_timing <= (tc_wr && st_r == EMT_IDLE) ? tc_wdata : tc_r;
    end
  end
endmodule
`default_nettype wire

// File: verif/emt_mem_model.sv
// Purpose: Behavioural external memory on the far side of the bus.
// Assumes: Only the low address byte selects a location.
// Notes: A released bus shows the inverse of the last read byte.
`default_nettype none
module emt_mem_model (
  input wire logic core_clk, // clock
  input wire logic mux, // multiplexed cycles
  input wire logic ale, // latch enable
  input wire logic rd_b, // read strobe
  input wire logic wr_b, // write strobe
  input wire logic [7:0] addr_lo, // low address
  input wire logic [7:0] ad_out, // bus from design
  output logic [7:0] ad_in // bus to design
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256];
  logic [7:0] lat = 8'h0;
  logic [7:0] last = 8'h0;
  wire logic [7:0] a = mux ? lat : addr_lo;
  always @(negedge ale) lat <= ad_out;
  always @(posedge wr_b) mem[a] <= ad_out;
  always @(negedge core_clk) if (!rd_b) last <= mem[a];
  // Stale data would let a late sample pass, so a released bus is inverted.
  assign ad_in = rd_b ? ~last : mem[a];
endmodule
`default_nettype wire

// File: verif/emt_seq_checker.sv
// Purpose: Pin timing assertions for the bus sequencer.
// Assumes: The mode field is held steady during a move.
// Notes: Data timing is watched on the lower ports only.
`default_nettype none
module emt_seq_checker (
  input wire logic core_clk, // clock
  input wire logic rst_b, // reset
  input wire logic [2:0] ext_mem_config, // mode
  input wire logic busy, // busy
  input wire logic done, // done
  input wire logic [7:0] rd_data, // read data
  input wire logic [7:0] lo_ad_in, // bus in
  input wire logic [7:0] lo_ad_out, // bus out
  input wire logic lo_ad_oe, // bus enable
  input wire logic lo_ale, // latch
  input wire logic lo_rd_b, // read
  input wire logic lo_wr_b, // write
  input wire logic up_ale, // latch
  input wire logic up_rd_b, // read
  input wire logic up_wr_b // write
);
  wire logic ale = lo_ale | up_ale;
  wire logic stb_lo = !(lo_rd_b & lo_wr_b);
  wire logic stb_up = !(up_rd_b & up_wr_b);
  wire logic stb = stb_lo | stb_up;
  logic [2:0] ale_cnt_r;
  logic [2:0] ale_cnt_nxt;
  assign ale_cnt_nxt = ale ? ale_cnt_r + 3'h1 : 3'h0;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) ale_cnt_r <= 3'h0;
    else ale_cnt_r <= ale_cnt_nxt;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  sequence ale_gap; (!ale && !stb) [*2]; endsequence
  sequence stb_on; ##[0:6] stb; endsequence
  strobe_excl_a: assert property ((lo_rd_b | lo_wr_b) && (up_rd_b | up_wr_b))
    else $error("both strobes low");
  route_excl_a: assert property (!((stb_lo | lo_ale) && (stb_up | up_ale)))
    else $error("both port groups active");
  idle_quiet_a: assert property (!busy |-> !stb && !ale && !lo_ad_oe)
    else $error("bus active while idle");
  ale_mux_a: assert property ($rose(ale) |-> !ext_mem_config[2])
    else $error("latch enable in non-multiplexed mode");
  ale_high_a: assert property ($fell(ale) |-> ale_cnt_r inside {[3'h1:3'h4]})
    else $error("latch enable high time out of range");
  ale_low_a: assert property ($fell(ale) |-> ale_gap ##1 stb_on)
    else $error("latch enable low time out of range");
  min_move_a: assert property ($rose(busy) |-> busy [*5])
    else $error("move shorter than five cycles");
  done_end_a: assert property ($fell(busy) |-> done ##1 !done)
    else $error("done not a pulse at move end");
  wr_setup_a: assert property (!lo_wr_b |-> lo_ad_oe && $stable(lo_ad_out))
    else $error("write data not set up");
  wr_hold_a: assert property ($rose(lo_wr_b) |-> lo_ad_oe && $stable(lo_ad_out))
    else $error("write data not held");
  rd_sample_a: assert property ($rose(lo_rd_b) |-> rd_data == $past(lo_ad_in))
    else $error("read data not sampled at strobe end");
endmodule
bind emt_seq emt_seq_checker i_emt_seq_checker (.core_clk(core_clk), .rst_b(rst_b),
  .ext_mem_config(ext_mem_config), .busy(busy), .done(done), .rd_data(rd_data),
  .lo_ad_in(lo_ad_in), .lo_ad_out(lo_ad_out), .lo_ad_oe(lo_ad_oe), .lo_ale(lo_ale),
  .lo_rd_b(lo_rd_b), .lo_wr_b(lo_wr_b), .up_ale(up_ale), .up_rd_b(up_rd_b), .up_wr_b(up_wr_b));
`default_nettype wire

// File: verif/emt_seq_test.sv
// Purpose: Self-checking bench for the bus sequencer.
// Assumes: One memory model follows the selected port group.
// Notes: Each write is read back at the same low address byte.
`default_nettype none
module emt_seq_test;
  import emt_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [7:0] cyc; logic rd; logic up; logic hi_oe; logic [7:0] hi;
    logic [7:0] dat; logic lo_oe; logic [7:0] lo;} emt_note_type;
  emt_note_type q[$];
  logic core_clk, rst_b, port_select_upper, tc_wr, req, req_write, req_wide;
  logic [2:0] ext_mem_config;
  logic [1:0] ale_width_cfg;
  logic [7:0] ext_mem_page, tc_wdata, indirect_pointer, wr_data, ext_mem_timing, rd_data;
  logic [15:0] wide_data_pointer;
  logic busy, done, lo_addr_hi_oe, lo_addr_lo_oe, lo_ad_oe, lo_ale, lo_rd_b, lo_wr_b;
  logic up_addr_hi_oe, up_addr_lo_oe, up_ad_oe, up_ale, up_rd_b, up_wr_b;
  logic [7:0] lo_addr_hi, lo_addr_lo, lo_ad_out, up_addr_hi, up_addr_lo, up_ad_out, mem_d;
  logic [7:0] cnt = 8'h0;
  logic [31:0] seed = 32'h49;
  int error_cnt = 0;
  int checked = 0;
  wire logic up = port_select_upper;
  emt_seq i_emt_seq (.core_clk(core_clk), .rst_b(rst_b), .ext_mem_config(ext_mem_config),
    .ale_width_cfg(ale_width_cfg), .port_select_upper(up), .ext_mem_page(ext_mem_page),
    .tc_wr(tc_wr), .tc_wdata(tc_wdata), .req(req), .req_write(req_write), .req_wide(req_wide),
    .wide_data_pointer(wide_data_pointer), .indirect_pointer(indirect_pointer),
    .wr_data(wr_data), .ext_mem_timing(ext_mem_timing), .busy(busy), .done(done),
    .rd_data(rd_data), .lo_addr_hi(lo_addr_hi), .lo_addr_hi_oe(lo_addr_hi_oe),
    .lo_addr_lo(lo_addr_lo), .lo_addr_lo_oe(lo_addr_lo_oe), .lo_ad_out(lo_ad_out),
    .lo_ad_oe(lo_ad_oe), .lo_ad_in(mem_d), .lo_ale(lo_ale), .lo_rd_b(lo_rd_b),
    .lo_wr_b(lo_wr_b), .up_addr_hi(up_addr_hi), .up_addr_hi_oe(up_addr_hi_oe),
    .up_addr_lo(up_addr_lo), .up_addr_lo_oe(up_addr_lo_oe), .up_ad_out(up_ad_out),
    .up_ad_oe(up_ad_oe), .up_ad_in(mem_d), .up_ale(up_ale), .up_rd_b(up_rd_b),
    .up_wr_b(up_wr_b));
  emt_mem_model i_emt_mem_model (.core_clk(core_clk), .mux(!ext_mem_config[2]),
    .ale(up ? up_ale : lo_ale), .rd_b(up ? up_rd_b : lo_rd_b), .wr_b(up ? up_wr_b : lo_wr_b),
    .addr_lo(up ? up_addr_lo : lo_addr_lo), .ad_out(up ? up_ad_out : lo_ad_out), .ad_in(mem_d));
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // A timing load is attempted mid-move; it must be refused while busy.
  task automatic move(input logic wr, input logic wide, input logic [2:0] mode);
    emt_note_type n;
    logic [31:0] r;
    r = xs();
    @(negedge core_clk);
    ext_mem_config = mode;
    tc_wdata = r[7:0];
    tc_wr = 1'b1;
    ale_width_cfg = r[9:8];
    port_select_upper = r[10];
    ext_mem_page = r[23:16];
    @(negedge core_clk);
    {tc_wr, req, req_write, req_wide} = {1'b0, 1'b1, wr, wide};
    n.cyc = 8'h5 + r[7:6] + r[5:2] + r[1:0] + (mode[2] ? 8'h0 : 8'h2 + {ale_width_cfg, 1'b0});
    n.rd = !wr;
    n.up = r[10];
    n.hi_oe = wide | (mode[1:0] == 2'h2);
    n.hi = wide ? wide_data_pointer[15:8] : r[23:16];
    n.dat = wr_data;
    n.lo_oe = mode[2];
    n.lo = wide ? wide_data_pointer[7:0] : indirect_pointer;
    q.push_back(n);
    @(negedge core_clk);
    {tc_wr, tc_wdata} = {1'b1, ~r[7:0]};
    @(negedge core_clk);
    tc_wr = 1'b0;
    for (int i = 0; i < 200 && done !== 1'b1; i++) @(negedge core_clk);
    check(done, 1'b1);
    req = 1'b0;
    check(ext_mem_timing, r[7:0]);
  endtask
  always @(posedge core_clk) begin
    if (busy === 1'b1) cnt = cnt + 8'h1;
    if (q.size() > 0 && (q[0].up ? !(up_rd_b & up_wr_b) : !(lo_rd_b & lo_wr_b))) begin
      check(q[0].up ? up_addr_hi_oe : lo_addr_hi_oe, q[0].hi_oe);
      if (q[0].hi_oe) check(q[0].up ? up_addr_hi : lo_addr_hi, q[0].hi);
      check(q[0].up ? up_addr_lo_oe : lo_addr_lo_oe, q[0].lo_oe);
      if (q[0].lo_oe) check(q[0].up ? up_addr_lo : lo_addr_lo, q[0].lo);
    end
    if (done === 1'b1 && q.size() > 0) begin
      check(cnt, q[0].cyc);
      if (q[0].rd) check(rd_data, q[0].dat);
      void'(q.pop_front());
      cnt = 8'h0;
    end
  end
  initial begin
    #20000;
    error_cnt++;
    wrap_up();
  end
  initial begin
    logic [2:0] modes [6];
    logic [31:0] r;
    modes = '{3'h1, 3'h2, 3'h3, 3'h5, 3'h6, 3'h7};
    {rst_b, port_select_upper, tc_wr, req, req_write, req_wide} = 6'h0;
    {ext_mem_config, ale_width_cfg, ext_mem_page, tc_wdata} = 21'h0;
    {wide_data_pointer, indirect_pointer, wr_data} = 32'h0;
    repeat (10) @(negedge core_clk);
    rst_b = 1'b1;
    check(ext_mem_timing, 8'hff);
    foreach (modes[m]) begin
      for (int w = 0; w < 2; w++) begin
        r = xs();
        {wide_data_pointer, indirect_pointer, wr_data} = r;
        move(1'b1, w[0], modes[m]);
        move(1'b0, w[0], modes[m]);
      end
    end
    repeat (3) @(negedge core_clk);
    check(8'(q.size()), 8'h0);
    wrap_up();
  end
endmodule
`default_nettype wire
